// ### gpc_pkg.sv
package gpc_pkg;

	// ----------------------------------------------------------------
	// pin counts and qualifier shape
	// ----------------------------------------------------------------
	localparam int NUM_PINS      = 24;
	localparam int LOW_PINS      = 16;
	localparam int HIGH_PINS     = 8;
	localparam int GROUP_SIZE    = 8;
	localparam int NUM_GROUPS    = 3;
	localparam int SYNC_STAGES   = 2;
	localparam int SAMPLES_SHORT = 3;
	localparam int SAMPLES_LONG  = 6;
	localparam int PERIOD_W      = 8;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_MUX_LOW  = 8'h00;
	localparam logic [7:0] OFS_MUX_HIGH = 8'h04;
	localparam logic [7:0] OFS_QSEL_LOW = 8'h08;
	localparam logic [7:0] OFS_QSEL_HI  = 8'h0C;
	localparam logic [7:0] OFS_CTRL     = 8'h10;
	localparam logic [7:0] OFS_DOUT     = 8'h14;
	localparam logic [7:0] OFS_DIR      = 8'h18;
	localparam logic [7:0] OFS_PIN_IN   = 8'h1C;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_MUX_LOW  = 32'h0000_0000;
	localparam logic [15:0] RST_MUX_HIGH = 16'h0000;
	localparam logic [31:0] RST_QSEL_LOW = 32'h0000_0000;
	localparam logic [15:0] RST_QSEL_HI  = 16'h0000;
	localparam logic [23:0] RST_CTRL     = 24'h00_0000;
	localparam logic [23:0] RST_DOUT     = 24'h00_0000;
	localparam logic [23:0] RST_DIR      = 24'h00_0000;

	typedef enum logic [1:0] {
		QUAL_SYNC,
		QUAL_WIN3,
		QUAL_WIN6,
		QUAL_ASYNC
	} gpc_qual_t;

	typedef struct packed {
		logic [31:0] muxLow;
		logic [15:0] muxHigh;
		logic [31:0] qselLow;
		logic [15:0] qselHigh;
		logic [23:0] ctrl;
		logic [23:0] dout;
		logic [23:0] dir;
	} gpc_regs_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] ofs;
	} gpc_aphase_t;

	// two-bit field of pin idx within a select register
	function automatic logic [1:0] sel2(input logic [31:0] value, input int idx);
		sel2 = value[2*idx +: 2];
	endfunction

endpackage

// ### gpc_sample_timer.sv
`timescale 1ns/1ps
`default_nettype none

module gpc_sample_timer (
	input  wire logic                           clk_sys,
	input  wire logic                           sys_rst,
	input  wire logic [gpc_pkg::PERIOD_W-1:0]   period,
	output logic                                tick
);

	logic [gpc_pkg::PERIOD_W:0] cnt_q;
	logic [gpc_pkg::PERIOD_W:0] cnt_d;

	// ----------------------------------------------------------------
	// sample spacing: 2*period clocks, period 0 samples every clock
	// ----------------------------------------------------------------
	always_comb begin
		tick  = (cnt_q == '0);
		cnt_d = cnt_q - 1'b1;
		if (tick) begin
			cnt_d = (period == '0) ? '0 : {period, 1'b0} - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	a_tick_spacing: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(tick && period == 8'h02) |=> (!tick)[*3] ##1 tick)
		else $error("sample tick spacing wrong for period two");

endmodule // gpc_sample_timer

`default_nettype wire

// ### gpc_input_qual.sv
`timescale 1ns/1ps
`default_nettype none

module gpc_input_qual (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              pinRaw,
	input  wire gpc_pkg::gpc_qual_t mode,
	input  wire logic              tick,
	output logic                   qualOut
);

	logic                               sync1_q;
	logic                               sync2_q;
	logic [gpc_pkg::SAMPLES_LONG-1:0]   hist_q;
	logic [gpc_pkg::SAMPLES_LONG-1:0]   hist_d;
	logic                               qual_q;
	logic                               qual_d;
	logic                               same3;
	logic                               same6;
	logic                               isWindow;

	// ----------------------------------------------------------------
	// sampling window
	// ----------------------------------------------------------------
	always_comb begin
		same3 = (&hist_q[gpc_pkg::SAMPLES_SHORT-1:0]) | ~(|hist_q[gpc_pkg::SAMPLES_SHORT-1:0]);
		same6 = (&hist_q) | ~(|hist_q);
		isWindow = (mode == gpc_pkg::QUAL_WIN3) || (mode == gpc_pkg::QUAL_WIN6);
		hist_d = tick ? {hist_q[gpc_pkg::SAMPLES_LONG-2:0], sync2_q} : hist_q;
		qual_d = sync2_q;
		if (isWindow) begin
			qual_d = qual_q;
			if ((mode == gpc_pkg::QUAL_WIN3) ? same3 : same6) begin
				qual_d = hist_q[0];
			end
		end
		case (mode)
			gpc_pkg::QUAL_SYNC:  qualOut = sync2_q;
			gpc_pkg::QUAL_ASYNC: qualOut = pinRaw;
			default:             qualOut = qual_q;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			hist_q  <= '0;
			qual_q  <= 1'b0;
		end else begin
			sync1_q <= pinRaw;
			sync2_q <= sync1_q;
			hist_q  <= hist_d;
			qual_q  <= qual_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence sWin6Mixed;
		(mode == gpc_pkg::QUAL_WIN6) && !same6;
	endsequence

	sequence sWin3Ones;
		(mode == gpc_pkg::QUAL_WIN3) && (hist_q[2:0] == 3'h7) && (hist_q[5:3] != 3'h7);
	endsequence

	a_sync_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == gpc_pkg::QUAL_SYNC) && !$past(sys_rst) && !$past(sys_rst, 2)
		|-> qualOut == $past(pinRaw, 2))
		else $error("sync-only path is not two clocks");

	a_async_pass: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == gpc_pkg::QUAL_ASYNC) |-> qualOut == pinRaw)
		else $error("async mode does not pass the pin");

	a_window_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sWin6Mixed ##1 (mode == gpc_pkg::QUAL_WIN6) |-> $stable(qualOut))
		else $error("window output moved on mixed samples");

	a_win3_update: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sWin3Ones ##1 (mode == gpc_pkg::QUAL_WIN3) |-> qualOut)
		else $error("three-sample window did not update");

	a_win6_update: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == gpc_pkg::QUAL_WIN6 && hist_q == 6'h00) ##1 (mode == gpc_pkg::QUAL_WIN6)
		|-> !qualOut)
		else $error("six-sample window did not update");

endmodule // gpc_input_qual

`default_nettype wire

// ### gpc_port_top.sv
`timescale 1ns/1ps
`default_nettype none

module gpc_port_top #(
	parameter logic [15:0] DATA_IDLE_LEVEL = 16'h0000
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic [23:0] pinIn,
	output logic [23:0]      pinOut,
	output logic [23:0]      pinOe,
	input  wire logic [15:0] extDataOut,
	input  wire logic        extDataOe,
	output logic [15:0]      extDataIn,
	input  wire logic [7:0]  extAddr
);

	gpc_pkg::gpc_regs_t   regs_q;
	gpc_pkg::gpc_regs_t   regs_d;
	gpc_pkg::gpc_aphase_t aph_q;
	gpc_pkg::gpc_aphase_t aph_d;
	logic [31:0]          hrdata_q;
	logic [31:0]          hrdata_d;
	logic [23:0]          pinOut_q;
	logic [23:0]          pinOut_d;
	logic [23:0]          pinOe_q;
	logic [23:0]          pinOe_d;
	logic [23:0]          qualIn;
	logic [23:0]          pinMuxed;
	logic [1:0]           pinQsel   [gpc_pkg::NUM_PINS];
	logic [2:0]           groupTick;

	// ----------------------------------------------------------------
	// bus slave: zero wait, always okay
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	function automatic logic [31:0] readReg(input gpc_pkg::gpc_regs_t r,
		input logic [7:0] ofs, input logic [23:0] pins);
		case (ofs)
			gpc_pkg::OFS_MUX_LOW:  readReg = r.muxLow;
			gpc_pkg::OFS_MUX_HIGH: readReg = {16'h0000, r.muxHigh};
			gpc_pkg::OFS_QSEL_LOW: readReg = r.qselLow;
			gpc_pkg::OFS_QSEL_HI:  readReg = {16'h0000, r.qselHigh};
			gpc_pkg::OFS_CTRL:     readReg = {8'h00, r.ctrl};
			gpc_pkg::OFS_DOUT:     readReg = {8'h00, r.dout};
			gpc_pkg::OFS_DIR:      readReg = {8'h00, r.dir};
			gpc_pkg::OFS_PIN_IN:   readReg = {8'h00, pins};
			default:               readReg = 32'h0000_0000;
		endcase
	endfunction

	always_comb begin
		aph_d.valid = hsel && hready && htrans[1];
		aph_d.write = hwrite;
		aph_d.ofs   = haddr[7:0];
		regs_d      = regs_q;
		if (aph_q.valid && aph_q.write) begin
			case (aph_q.ofs)
				gpc_pkg::OFS_MUX_LOW:  regs_d.muxLow   = hwdata;
				gpc_pkg::OFS_MUX_HIGH: regs_d.muxHigh  = hwdata[15:0];
				gpc_pkg::OFS_QSEL_LOW: regs_d.qselLow  = hwdata;
				gpc_pkg::OFS_QSEL_HI:  regs_d.qselHigh = hwdata[15:0];
				gpc_pkg::OFS_CTRL:     regs_d.ctrl     = hwdata[23:0];
				gpc_pkg::OFS_DOUT:     regs_d.dout     = hwdata[23:0];
				gpc_pkg::OFS_DIR:      regs_d.dir      = hwdata[23:0];
				default:               regs_d          = regs_q;
			endcase
		end
		// forward the pending write so a back-to-back read sees it
		hrdata_d = hrdata_q;
		if (aph_d.valid && !aph_d.write) begin
			hrdata_d = readReg(regs_d, aph_d.ofs, qualIn);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			regs_q.muxLow   <= gpc_pkg::RST_MUX_LOW;
			regs_q.muxHigh  <= gpc_pkg::RST_MUX_HIGH;
			regs_q.qselLow  <= gpc_pkg::RST_QSEL_LOW;
			regs_q.qselHigh <= gpc_pkg::RST_QSEL_HI;
			regs_q.ctrl     <= gpc_pkg::RST_CTRL;
			regs_q.dout     <= gpc_pkg::RST_DOUT;
			regs_q.dir      <= gpc_pkg::RST_DIR;
			aph_q           <= '0;
			hrdata_q        <= 32'h0000_0000;
		end else begin
			regs_q   <= regs_d;
			aph_q    <= aph_d;
			hrdata_q <= hrdata_d;
		end
	end

	// ----------------------------------------------------------------
	// per-group sample timers
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < gpc_pkg::NUM_GROUPS; g++) begin : gen_group
			gpc_sample_timer u_timer (
				.clk_sys (clk_sys),
				.sys_rst (sys_rst),
				.period  (regs_q.ctrl[g*gpc_pkg::PERIOD_W +: gpc_pkg::PERIOD_W]),
				.tick    (groupTick[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// per-pin qualifiers
	// ----------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < gpc_pkg::NUM_PINS; p++) begin : gen_pin
			if (p < gpc_pkg::LOW_PINS) begin : gen_low
				assign pinQsel[p]  = gpc_pkg::sel2(regs_q.qselLow, p);
				assign pinMuxed[p] = gpc_pkg::sel2(regs_q.muxLow, p) >= 2'b10;
			end else begin : gen_high
				assign pinQsel[p]  = gpc_pkg::sel2({16'h0000, regs_q.qselHigh},
					p - gpc_pkg::LOW_PINS);
				assign pinMuxed[p] = gpc_pkg::sel2({16'h0000, regs_q.muxHigh},
					p - gpc_pkg::LOW_PINS) >= 2'b10;
			end
			gpc_input_qual u_qual (
				.clk_sys (clk_sys),
				.sys_rst (sys_rst),
				.pinRaw  (pinIn[p]),
				.mode    (gpc_pkg::gpc_qual_t'(pinQsel[p])),
				.tick    (groupTick[p / gpc_pkg::GROUP_SIZE]),
				.qualOut (qualIn[p])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// output mux and external data input
	// ----------------------------------------------------------------
	always_comb begin
		pinOut_d  = regs_q.dout;
		pinOe_d   = regs_q.dir;
		extDataIn = DATA_IDLE_LEVEL;
		for (int i = 0; i < gpc_pkg::LOW_PINS; i++) begin
			if (pinMuxed[i]) begin
				pinOut_d[i]       = extDataOut[15-i];
				pinOe_d[i]        = extDataOe;
				extDataIn[15-i]   = qualIn[i];
			end
		end
		for (int k = 0; k < gpc_pkg::HIGH_PINS; k++) begin
			if (pinMuxed[gpc_pkg::LOW_PINS + k]) begin
				pinOut_d[gpc_pkg::LOW_PINS + k] = extAddr[k];
				pinOe_d[gpc_pkg::LOW_PINS + k]  = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pinOut_q <= 24'h00_0000;
			pinOe_q  <= 24'h00_0000;
		end else begin
			pinOut_q <= pinOut_d;
			pinOe_q  <= pinOe_d;
		end
	end

	assign pinOut = pinOut_q;
	assign pinOe  = pinOe_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_mux_data_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
		regs_q.muxLow[1] |=> pinOut[0] == $past(extDataOut[15]) && pinOe[0] == $past(extDataOe))
		else $error("pin 0 not routed to data bit 15");

	a_mux_gpio_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!regs_q.muxLow[31] |=> pinOut[15] == $past(regs_q.dout[15])
			&& pinOe[15] == $past(regs_q.dir[15]))
		else $error("pin 15 not on gpio when select is 0x");

	a_mux_addr_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
		regs_q.muxHigh[15] |=> pinOut[23] == $past(extAddr[7]) && pinOe[23])
		else $error("pin 23 not routed to address bit 15");

	a_qsel_reset: assert property (@(posedge clk_sys)
		sys_rst |=> regs_q.qselLow == 32'h0000_0000 && regs_q.qselHigh == 16'h0000)
		else $error("qualification select not cleared by reset");

	a_idle_default: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!regs_q.muxLow[1] |-> extDataIn[15] == DATA_IDLE_LEVEL[15])
		else $error("unselected data input not at default");

	a_data_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
		regs_q.muxLow[31] |-> extDataIn[0] == qualIn[15])
		else $error("selected data input not from its pin");

	// ----------------------------------------------------------------
	// register write, read-back and further routing checks
	// ----------------------------------------------------------------
	sequence sMuxLowWrite;
		hsel && hready && htrans[1] && hwrite && (haddr[7:0] == gpc_pkg::OFS_MUX_LOW);
	endsequence

	sequence sMuxHighWrite;
		hsel && hready && htrans[1] && hwrite && (haddr[7:0] == gpc_pkg::OFS_MUX_HIGH);
	endsequence

	sequence sQselLowWrite;
		hsel && hready && htrans[1] && hwrite && (haddr[7:0] == gpc_pkg::OFS_QSEL_LOW);
	endsequence

	sequence sQselHighWrite;
		hsel && hready && htrans[1] && hwrite && (haddr[7:0] == gpc_pkg::OFS_QSEL_HI);
	endsequence

	sequence sCtrlWrite;
		hsel && hready && htrans[1] && hwrite && (haddr[7:0] == gpc_pkg::OFS_CTRL);
	endsequence

	// read address phase with no write pending in its data phase
	sequence sQselLowRead;
		hsel && hready && htrans[1] && !hwrite && (haddr[7:0] == gpc_pkg::OFS_QSEL_LOW)
			&& !(aph_q.valid && aph_q.write);
	endsequence

	a_mux_low_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sMuxLowWrite |-> ##2 regs_q.muxLow == $past(hwdata))
		else $error("low mux register did not take the written word");

	a_mux_high_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sMuxHighWrite |-> ##2 regs_q.muxHigh == $past(hwdata[15:0]))
		else $error("high mux register did not take the written word");

	a_qsel_low_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sQselLowWrite |-> ##2 regs_q.qselLow == $past(hwdata))
		else $error("low qualification select did not take the written word");

	a_qsel_high_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sQselHighWrite |-> ##2 regs_q.qselHigh == $past(hwdata[15:0]))
		else $error("high qualification select did not take the written word");

	a_period_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sCtrlWrite |-> ##2 regs_q.ctrl == $past(hwdata[23:0]))
		else $error("sample period fields did not take the written word");

	a_qsel_readback: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sQselLowRead |=> hrdata == $past(regs_q.qselLow))
		else $error("low qualification select read back wrong");

	a_data_route_last: assert property (@(posedge clk_sys) disable iff (sys_rst)
		regs_q.muxLow[31] |=> pinOut[15] == $past(extDataOut[0])
			&& pinOe[15] == $past(extDataOe))
		else $error("pin 15 not routed to data bit 0");

	a_gpio_route_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!regs_q.muxLow[1] |=> pinOut[0] == $past(regs_q.dout[0])
			&& pinOe[0] == $past(regs_q.dir[0]))
		else $error("pin 0 not on gpio when select is 0x");

	a_addr_route_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
		regs_q.muxHigh[1] |=> pinOut[16] == $past(extAddr[0]) && pinOe[16])
		else $error("pin 16 not routed to address bit 8");

	a_gpio_route_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!regs_q.muxHigh[15] |=> pinOut[23] == $past(regs_q.dout[23])
			&& pinOe[23] == $past(regs_q.dir[23]))
		else $error("pin 23 not on gpio when select is 0x");

	a_idle_default_lsb: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!regs_q.muxLow[31] |-> extDataIn[0] == DATA_IDLE_LEVEL[0])
		else $error("unselected data bit 0 not at default");

	a_data_select_msb: assert property (@(posedge clk_sys) disable iff (sys_rst)
		regs_q.muxLow[1] |-> extDataIn[15] == qualIn[0])
		else $error("data bit 15 not taken from pin 0");

endmodule // gpc_port_top

`default_nettype wire

// ### gpc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module gpc_pin_model (
	input  wire logic [23:0] drive,
	input  wire logic [23:0] pinOut,
	input  wire logic [23:0] pinOe,
	output logic      [23:0] pinIn
);
	// a pin the block drives reads back its own level
	assign pinIn = (pinOe & pinOut) | (~pinOe & drive);
endmodule // gpc_pin_model

`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin numErrors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

module testbench;
	localparam logic [15:0] IDLE = 16'hA5C3;
	logic        clk_sys    = 1'b0;
	logic        sys_rst    = 1'b1;
	logic        hsel       = 1'b0;
	logic [31:0] haddr      = 32'h0000_0000;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [31:0] hwdata     = 32'h0000_0000;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic [23:0] pinIn;
	logic [23:0] pinOut;
	logic [23:0] pinOe;
	logic [23:0] drive      = 24'h00_0000;
	logic [15:0] extDataOut = 16'h0000;
	logic        extDataOe  = 1'b0;
	logic [15:0] extDataIn;
	logic [7:0]  extAddr    = 8'h00;
	logic [31:0] rnd        = 32'h0000_0050;
	logic [31:0] rd;
	logic [31:0] ml;
	logic [15:0] mh;
	logic [23:0] dout;
	logic [23:0] dir;
	logic        seen;
	int          numErrors  = 0;
	int          nCompared  = 0;
	int          cycles     = 0;
	int          n;
	int          pins[3]    = '{0, 3, 8};
	int          smp[3]     = '{3, 6, 3};
	int          per[3]     = '{2, 2, 4};

	gpc_port_top #(.DATA_IDLE_LEVEL(IDLE)) u_dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .extDataOut(extDataOut),
		.extDataOe(extDataOe), .extDataIn(extDataIn), .extAddr(extAddr)
	);

	gpc_pin_model u_pins (.drive(drive), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

	// ----------------------------------------------------------------
	// clock, timeout, helpers
	// ----------------------------------------------------------------
	always #4 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			results();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	// {oe, out} the pins should show for a register setting
	function automatic logic [47:0] expPins(input logic [31:0] l, input logic [15:0] h,
		input logic [23:0] o, input logic [23:0] d);
		logic [47:0] e;
		e = {d, o};
		for (int i = 0; i < 16; i++) if (l[2*i+1]) begin
			e[i] = extDataOut[15-i];
			e[24+i] = extDataOe;
		end
		for (int k = 0; k < 8; k++) if (h[2*k+1]) begin
			e[16+k] = extAddr[k];
			e[40+k] = 1'b1;
		end
		return e;
	endfunction

	// two clocks before the earliest qualified change after a pin edge
	function automatic int winLo(input int s, input int p);
		return (s - 1) * 2 * p + 2;
	endfunction

	task automatic busXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic waitBit(input int idx, input logic v);
		n = 0;
		#1;
		while (extDataIn[idx] !== v && n < 100) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask

	task automatic results;
		$display("compared %0d errors %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int a = 0; a <= 32; a += 4) begin
			busXfer(1'b0, a[7:0], 32'h0000_0000);
			`CHK(rd, 32'h0000_0000)
		end
		`CHK(pinOe, 24'h00_0000)
		`CHK(extDataIn, IDLE)
		for (int i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			ml = (i < 4) ? {16{i[1:0]}} : rnd;
			mh = (i < 4) ? {8{i[1:0]}} : rnd[31:16];
			rnd = xs(rnd);
			dout = rnd[23:0];
			drive <= rnd[31:8];
			rnd = xs(rnd);
			dir = rnd[23:0];
			extDataOut <= rnd[31:16];
			extDataOe <= rnd[8];
			extAddr <= rnd[7:0];
			busXfer(1'b1, gpc_pkg::OFS_MUX_LOW, ml);
			busXfer(1'b1, gpc_pkg::OFS_MUX_HIGH, {16'h0000, mh});
			busXfer(1'b1, gpc_pkg::OFS_DOUT, {8'h00, dout});
			busXfer(1'b1, gpc_pkg::OFS_DIR, {8'h00, dir});
			repeat (2) @(posedge clk_sys);
			#1;
			`CHK({pinOe, pinOut}, expPins(ml, mh, dout, dir))
			busXfer(1'b0, gpc_pkg::OFS_MUX_HIGH, 32'h0000_0000);
			`CHK(rd, {16'h0000, mh})
			if ((ml & 32'hAAAA_AAAA) == 32'h0000_0000)
				`CHK(extDataIn, IDLE)
		end
		// data pins as inputs for the qualifier checks
		extDataOe <= 1'b0;
		drive <= 24'h00_0000;
		busXfer(1'b1, gpc_pkg::OFS_MUX_LOW, 32'hAAAA_AAAA);
		busXfer(1'b1, gpc_pkg::OFS_CTRL, 32'h0000_0402);
		busXfer(1'b1, gpc_pkg::OFS_QSEL_LOW, 32'h0001_00B1);
		busXfer(1'b0, gpc_pkg::OFS_QSEL_LOW, 32'h0000_0000);
		`CHK(rd, 32'h0001_00B1)
		busXfer(1'b1, gpc_pkg::OFS_QSEL_HI, rnd);
		busXfer(1'b0, gpc_pkg::OFS_QSEL_HI, 32'h0000_0000);
		`CHK(rd, {16'h0000, rnd[15:0]})
		`CHK(hresp, 1'b0)
		`CHK(hreadyout, 1'b1)
		repeat (60) @(posedge clk_sys);
		@(posedge clk_sys);
		drive[1] <= 1'b1;
		waitBit(14, 1'b1);
		`CHK(n, 2)
		busXfer(1'b0, gpc_pkg::OFS_PIN_IN, 32'h0000_0000);
		`CHK(rd[1], 1'b1)
		@(posedge clk_sys);
		drive[2] <= 1'b1;
		waitBit(13, 1'b1);
		`CHK(n, 0)
		for (int j = 0; j < 6; j++) begin
			@(posedge clk_sys);
			drive[pins[j%3]] <= (j < 3);
			waitBit(15 - pins[j%3], (j < 3));
			`CHK(n >= winLo(smp[j%3], per[j%3]) && n <= winLo(smp[j%3] + 1, per[j%3]) + 2, 1'b1)
		end
		// a pulse shorter than the window must not pass
		seen = 1'b0;
		for (int c = 0; c < 48; c++) begin
			@(posedge clk_sys);
			drive[0] <= (c < 7);
			#1;
			seen |= extDataIn[15];
		end
		`CHK(seen, 1'b0)
		results();
	end
endmodule // testbench

`default_nettype wire
